// ==== rtl/bdm_regs.svh ====
`ifndef BDM_REGS_SVH
`define BDM_REGS_SVH

// apb byte offsets
`define BDM_APB_BANK 12'h000
`define BDM_APB_PTR 12'h004
`define BDM_APB_PFLAG 12'h008
`define BDM_APB_IRQ_STAT 12'h00C
`define BDM_APB_IRQ_MASK 12'h010
`define BDM_APB_LAST_ADDR 12'h014

// in-bank layout seen by the core
`define BDM_SFR_STATUS 7'h03
`define BDM_SFR_PTR 7'h04
`define BDM_SFR_PFLAG 7'h0C
`define BDM_GPR_BASE 7'h20
`define BDM_BANK_TOP 7'h7F
`define BDM_GPR_PER_BANK 9'h060
`define BDM_GPR_WORDS 384

// status bit positions
`define BDM_BSEL_HI 6
`define BDM_BSEL_LO 5

// peripheral flag positions, read-only mask and reset
`define BDM_PF_PSP 7
`define BDM_PF_ADC 6
`define BDM_PF_RX 5
`define BDM_PF_TX 4
`define BDM_PF_RO_MASK 8'h30
`define BDM_PF_RESET 8'h00

// interrupt status bits
`define BDM_IRQ_PSP 0
`define BDM_IRQ_ADC 1
`define BDM_IRQ_RX 2
`define BDM_IRQ_W 3

`endif

// ==== rtl/bdm_pkg.sv ====
package bdm_pkg;

  // one core access: direct or through the pointer
  typedef struct packed {
    logic valid;
    logic write;
    logic indirect;
    logic [6:0] addr;
    logic [7:0] wdata;
  } bdm_core_req_type;

  // peripheral event inputs
  typedef struct packed {
    logic psp_rw;
    logic adc_done;
    logic rx_full;
    logic tx_empty;
    logic [3:0] other;
  } bdm_pevt_type;

  // what an in-bank address lands on
  typedef enum logic [2:0] {
    RG_STATUS,
    RG_PTR,
    RG_PFLAG,
    RG_GPR,
    RG_NONE
  } bdm_region_type;

endpackage

// ==== rtl/bdm_gpr_ram.sv ====
`include "bdm_regs.svh"

module bdm_gpr_ram
  import bdm_pkg::*;
(
  input wire logic i_core_clk, // core clock
  input wire logic i_we, // write strobe
  input wire logic [8:0] i_waddr, // word index
  input wire logic [7:0] i_wdata, // write byte
  input wire logic [8:0] i_raddr, // read index
  output logic [7:0] o_rdata // read byte, combinational
);

  logic [7:0] mem [`BDM_GPR_WORDS];

  // static ram store, no reset
  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // read path
  always_comb begin
    o_rdata = mem[i_raddr];
  end

endmodule // bdm_gpr_ram

// ==== rtl/bdm_pflag.sv ====
`include "bdm_regs.svh"

module bdm_pflag
  import bdm_pkg::*;
(
  input wire logic i_core_clk, // core clock
  input wire logic i_resetn, // async reset, low
  input wire bdm_pevt_type i_evt, // event conditions
  input wire logic i_wr, // software write strobe
  input wire logic [7:0] i_wdata, // software write byte
  output logic [7:0] o_flags // flag register
);

  logic [7:0] set_vec;
  logic [7:0] ro_mask;
  logic [7:0] flag_r;
  logic [7:0] flag_nxt;

  // condition vector in flag order
  always_comb begin
    set_vec = {i_evt.psp_rw, i_evt.adc_done, i_evt.rx_full,
               i_evt.tx_empty, i_evt.other};
    ro_mask = `BDM_PF_RO_MASK;
  end

  // one flag bit per source
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      always_comb begin
        if (ro_mask[gi]) begin
          flag_nxt[gi] = set_vec[gi];
        end else if (set_vec[gi]) begin
          flag_nxt[gi] = 1'b1;
        end else if (i_wr) begin
          flag_nxt[gi] = i_wdata[gi];
        end else begin
          flag_nxt[gi] = flag_r[gi];
        end
      end
      always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          flag_r[gi] <= 1'b0;
        end else begin
          flag_r[gi] <= flag_nxt[gi];
        end
      end
    end
  endgenerate

  assign o_flags = flag_r;

  a_pf_set_wins: assert property (@(posedge i_core_clk) disable iff
    (!i_resetn) i_evt.adc_done |=> o_flags[`BDM_PF_ADC])
    else $error("converter flag missed its event");
  a_pf_ro_track: assert property (@(posedge i_core_clk) disable iff
    (!i_resetn) ##1 o_flags[`BDM_PF_RX] == $past(i_evt.rx_full))
    else $error("receive flag does not follow buffer");

endmodule // bdm_pflag

// ==== rtl/bdm_top.sv ====
// Behaviour
// - two status bits pick one of four banks
// - each bank holds up to 128 bytes
// - special registers sit at low bank addresses
// - addresses above them are static ram
// - every bank holds some special registers
// - busy special registers mirrored across banks
// - access direct or through pointer register
// - one flag bit per peripheral source
// - flags set regardless of any enable
// - parallel port flag sticks until cleared
// - converter flag set on conversion done
// - receive flag read-only, shows buffer full
//
// Added by the designer: register access over APB and the placing of the registers.
`include "bdm_regs.svh"

module bdm_top
  import bdm_pkg::*;
(
  input wire logic i_core_clk, // core clock, 25 MHz
  input wire logic i_resetn, // async reset, low
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [11:0] i_paddr, // apb byte address
  input wire logic [31:0] i_pwdata, // apb write data
  output logic [31:0] o_prdata, // apb read data
  output logic o_pready, // apb ready
  output logic o_pslverr, // apb error, unmapped
  input wire bdm_core_req_type i_core_req, // core data access
  output logic [7:0] o_core_rdata, // core read byte
  output logic o_core_rvalid, // core read done pulse
  input wire bdm_pevt_type i_pevt, // peripheral conditions
  output logic [1:0] o_bank_sel, // active bank
  output logic [8:0] o_full_addr, // last full data address
  output logic [7:0] o_pflags, // peripheral flag register
  output logic o_irq // interrupt, level high
);

  // full address to target; shared by read and write paths
  function automatic bdm_region_type region_of(input logic [8:0] fa);
    logic [6:0] off;
    off = fa[6:0];
    if (off == `BDM_SFR_STATUS) begin
      region_of = RG_STATUS;
    end else if (off == `BDM_SFR_PTR) begin
      region_of = RG_PTR;
    end else if (off == `BDM_SFR_PFLAG && fa[8:7] == 2'b00) begin
      region_of = RG_PFLAG;
    end else if (off >= `BDM_GPR_BASE) begin
      region_of = RG_GPR;
    end else begin
      region_of = RG_NONE;
    end
  endfunction

  // gpr index: bank times 96 plus offset above the special area
  function automatic logic [8:0] gpr_index(input logic [8:0] fa);
    logic [8:0] base;
    base = 9'(fa[8:7]) * `BDM_GPR_PER_BANK;
    gpr_index = base + 9'(fa[6:0] - `BDM_GPR_BASE);
  endfunction

  logic [1:0] bank_r, bank_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic [8:0] last_r, last_nxt;
  logic [7:0] crd_r, crd_nxt;
  logic crv_r, crv_nxt;
  logic [31:0] prd_r, prd_nxt;
  logic err_r, err_nxt;
  logic [`BDM_IRQ_W-1:0] ist_r, ist_nxt;
  logic [`BDM_IRQ_W-1:0] imask_r, imask_nxt;
  logic rx_d_r, rx_d_nxt;
  logic [8:0] full_addr;
  bdm_region_type reg_sel;
  logic core_wr, ram_we;
  logic [8:0] ram_idx;
  logic [7:0] ram_rdata;
  logic [7:0] pflags;
  logic pf_wr;
  logic [7:0] pf_wdata;
  logic apb_setup, apb_wr;
  logic [`BDM_IRQ_W-1:0] ev_vec;

  // full data address from bank and offset, or from upper bank bit and pointer
  always_comb begin
    if (i_core_req.indirect) begin
      full_addr = {bank_r[1], ptr_r};
    end else begin
      full_addr = {bank_r, i_core_req.addr};
    end
    reg_sel = region_of(full_addr);
    core_wr = i_core_req.valid && i_core_req.write;
    ram_we = core_wr && (reg_sel == RG_GPR);
    ram_idx = gpr_index(full_addr);
  end

  // apb phase decode; zero wait states
  always_comb begin
    apb_setup = i_psel && !i_penable;
    apb_wr = i_psel && i_penable && i_pwrite;
    o_pready = 1'b1;
  end

  // peripheral flag write: core wins over apb in the same cycle
  always_comb begin
    pf_wr = 1'b0;
    pf_wdata = 8'h00;
    if (core_wr && reg_sel == RG_PFLAG) begin
      pf_wr = 1'b1;
      pf_wdata = i_core_req.wdata;
    end else if (apb_wr && i_paddr == `BDM_APB_PFLAG) begin
      pf_wr = 1'b1;
      pf_wdata = i_pwdata[7:0];
    end
  end

  // bank select, pointer and last address next state
  always_comb begin
    bank_nxt = bank_r;
    ptr_nxt = ptr_r;
    last_nxt = last_r;
    if (i_core_req.valid) begin
      last_nxt = full_addr;
    end
    if (core_wr && reg_sel == RG_STATUS) begin
      bank_nxt = {i_core_req.wdata[`BDM_BSEL_HI],
                  i_core_req.wdata[`BDM_BSEL_LO]};
    end else if (apb_wr && i_paddr == `BDM_APB_BANK) begin
      bank_nxt = {i_pwdata[`BDM_BSEL_HI], i_pwdata[`BDM_BSEL_LO]};
    end
    if (core_wr && reg_sel == RG_PTR) begin
      ptr_nxt = i_core_req.wdata;
    end else if (apb_wr && i_paddr == `BDM_APB_PTR) begin
      ptr_nxt = i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bank_r <= 2'h0;
      ptr_r <= 8'h00;
      last_r <= 9'h000;
    end else begin
      bank_r <= bank_nxt;
      ptr_r <= ptr_nxt;
      last_r <= last_nxt;
    end
  end

  // core read data, registered one cycle after the request
  always_comb begin
    crv_nxt = i_core_req.valid && !i_core_req.write;
    crd_nxt = crd_r;
    if (crv_nxt) begin
      if (reg_sel == RG_STATUS) begin
        crd_nxt = 8'h00;
        crd_nxt[`BDM_BSEL_HI] = bank_r[1];
        crd_nxt[`BDM_BSEL_LO] = bank_r[0];
      end else if (reg_sel == RG_PTR) begin
        crd_nxt = ptr_r;
      end else if (reg_sel == RG_PFLAG) begin
        crd_nxt = pflags;
      end else if (reg_sel == RG_GPR) begin
        crd_nxt = ram_rdata;
      end else begin
        crd_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      crd_r <= 8'h00;
      crv_r <= 1'b0;
    end else begin
      crd_r <= crd_nxt;
      crv_r <= crv_nxt;
    end
  end

  // interrupt status: set wins over write-one-to-clear
  always_comb begin
    rx_d_nxt = i_pevt.rx_full;
    ev_vec = '0;
    ev_vec[`BDM_IRQ_PSP] = i_pevt.psp_rw;
    ev_vec[`BDM_IRQ_ADC] = i_pevt.adc_done;
    ev_vec[`BDM_IRQ_RX] = i_pevt.rx_full && !rx_d_r;
    ist_nxt = ist_r;
    imask_nxt = imask_r;
    if (apb_wr && i_paddr == `BDM_APB_IRQ_STAT) begin
      ist_nxt = ist_r & ~i_pwdata[`BDM_IRQ_W-1:0];
    end
    if (apb_wr && i_paddr == `BDM_APB_IRQ_MASK) begin
      imask_nxt = i_pwdata[`BDM_IRQ_W-1:0];
    end
    ist_nxt = ist_nxt | ev_vec;
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ist_r <= '0;
      imask_r <= '0;
      rx_d_r <= 1'b0;
    end else begin
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      rx_d_r <= rx_d_nxt;
    end
  end

  // apb read data captured in the setup cycle
  always_comb begin
    prd_nxt = prd_r;
    err_nxt = err_r;
    if (apb_setup) begin
      err_nxt = 1'b0;
      if (i_paddr == `BDM_APB_BANK) begin
        prd_nxt = 32'(bank_r) << `BDM_BSEL_LO;
      end else if (i_paddr == `BDM_APB_PTR) begin
        prd_nxt = 32'(ptr_r);
      end else if (i_paddr == `BDM_APB_PFLAG) begin
        prd_nxt = 32'(pflags);
      end else if (i_paddr == `BDM_APB_IRQ_STAT) begin
        prd_nxt = 32'(ist_r);
      end else if (i_paddr == `BDM_APB_IRQ_MASK) begin
        prd_nxt = 32'(imask_r);
      end else if (i_paddr == `BDM_APB_LAST_ADDR) begin
        prd_nxt = 32'(last_r);
      end else begin
        prd_nxt = 32'h0000_0000;
        err_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      prd_r <= 32'h0000_0000;
      err_r <= 1'b0;
    end else begin
      prd_r <= prd_nxt;
      err_r <= err_nxt;
    end
  end

  bdm_gpr_ram bdm_gpr_ram_inst (
    .i_core_clk(i_core_clk),
    .i_we(ram_we),
    .i_waddr(ram_idx),
    .i_wdata(i_core_req.wdata),
    .i_raddr(ram_idx),
    .o_rdata(ram_rdata)
  );

  bdm_pflag bdm_pflag_inst (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_evt(i_pevt),
    .i_wr(pf_wr),
    .i_wdata(pf_wdata),
    .o_flags(pflags)
  );

  // outputs
  assign o_prdata = prd_r;
  assign o_pslverr = err_r && i_psel && i_penable;
  assign o_core_rdata = crd_r;
  assign o_core_rvalid = crv_r;
  assign o_bank_sel = bank_r;
  assign o_full_addr = last_r;
  assign o_pflags = pflags;
  assign o_irq = |(ist_r & imask_r);

  // gpr write then read of the same address returns the data
  sequence s_gpr_wr;
    ram_we && !i_core_req.indirect;
  endsequence

  a_bank_core_wr: assert property (@(posedge i_core_clk) disable iff
    (!i_resetn) (core_wr && reg_sel == RG_STATUS) |=>
    o_bank_sel == $past({i_core_req.wdata[6], i_core_req.wdata[5]}))
    else $error("bank select not taken from status write");
  a_gpr_in_range: assert property (@(posedge i_core_clk) disable iff
    (!i_resetn) ram_we |-> ram_idx < 9'(`BDM_GPR_WORDS))
    else $error("gpr index beyond storage");
  a_sfr_low_area: assert property (@(posedge i_core_clk) disable iff
    (!i_resetn) (crv_nxt && full_addr[6:0] < `BDM_GPR_BASE) |->
    !ram_we && reg_sel != RG_GPR)
    else $error("special area reached ram");
  a_gpr_readback: assert property (@(posedge i_core_clk) disable iff
    (!i_resetn) s_gpr_wr ##1 (crv_nxt && reg_sel == RG_GPR &&
    full_addr == $past(full_addr) && !core_wr) |=>
    o_core_rdata == $past(i_core_req.wdata, 2))
    else $error("gpr readback mismatch");
  a_status_mirror: assert property (@(posedge i_core_clk) disable iff
    (!i_resetn) (crv_nxt && reg_sel == RG_STATUS) |=>
    o_core_rdata[6:5] == $past(bank_r))
    else $error("status mirror wrong bank bits");
  a_indirect_addr: assert property (@(posedge i_core_clk) disable iff
    (!i_resetn) (i_core_req.valid && i_core_req.indirect) |=>
    o_full_addr == {$past(bank_r[1]), $past(ptr_r)})
    else $error("indirect address not from pointer");
  a_direct_addr: assert property (@(posedge i_core_clk) disable iff
    (!i_resetn) (i_core_req.valid && !i_core_req.indirect) |=>
    o_full_addr == {$past(bank_r), $past(i_core_req.addr)})
    else $error("direct address not bank over offset");
  a_psp_sets: assert property (@(posedge i_core_clk) disable iff
    (!i_resetn) i_pevt.psp_rw |=> o_pflags[`BDM_PF_PSP])
    else $error("parallel port flag not set");
  a_psp_holds: assert property (@(posedge i_core_clk) disable iff
    (!i_resetn) (o_pflags[`BDM_PF_PSP] && !pf_wr) |=>
    o_pflags[`BDM_PF_PSP])
    else $error("parallel port flag dropped by itself");
  a_ro_ignored: assert property (@(posedge i_core_clk) disable iff
    (!i_resetn) (pf_wr && !i_pevt.tx_empty) |=>
    !o_pflags[`BDM_PF_TX])
    else $error("read-only flag took a write");
  a_irq_level: assert property (@(posedge i_core_clk) disable iff
    (!i_resetn) (|(ev_vec & imask_r) && imask_nxt == imask_r) |=>
    o_irq)
    else $error("unmasked event gave no interrupt");

endmodule // bdm_top

// ==== sim/bdm_far_model.sv ====
module bdm_far_model
  import bdm_pkg::*;
(
  input wire logic i_core_clk, // core clock
  input wire logic i_rvalid, // read done pulse
  input wire logic [7:0] i_rdata, // read byte
  output bdm_core_req_type o_req, // core access
  output bdm_pevt_type o_pevt // event lines
);
  timeunit 1ns;
  timeprecision 1ps;
  int misses = 0;

  // idle core and quiet peripherals
  initial begin
    o_req = '0;
    o_pevt = '0;
  end

  // one byte access, valid for one cycle; a read waits for its answer
  task automatic core(input logic wr, ind, input logic [6:0] a,
      input logic [7:0] d, output logic [7:0] rd);
    int n;
    @(posedge i_core_clk);
    o_req <= '{1'b1, wr, ind, a, d};
    @(posedge i_core_clk);
    o_req <= '0;
    n = 0;
    while (!wr && n < 9) begin
      @(posedge i_core_clk);
      n = (i_rvalid === 1'b1) ? 99 : n + 1;
    end
    rd = i_rdata;
    if (n == 9) begin
      misses++;
    end
  endtask

  // write then read of one direct offset on back-to-back edges
  task automatic core_wr_rd(input logic [6:0] a, input logic [7:0] d,
      output logic [7:0] rd);
    @(posedge i_core_clk);
    o_req <= '{1'b1, 1'b1, 1'b0, a, d};
    @(posedge i_core_clk);
    o_req <= '{1'b1, 1'b0, 1'b0, a, d};
    @(posedge i_core_clk);
    o_req <= '0;
    @(posedge i_core_clk);
    rd = i_rdata;
    if (i_rvalid !== 1'b1) begin
      misses++;
    end
  endtask

  // level change on one event line, taken at the next edge
  task automatic set_evt(input int b, input logic v);
    @(posedge i_core_clk);
    o_pevt[b] <= v;
  endtask
endmodule // bdm_far_model

// ==== sim/banked_data_memory_select_bench.sv ====
`include "bdm_regs.svh"

module banked_data_memory_select_bench
  import bdm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [7:0] core_rdata, pflags, cb;
  logic [7:0] gd [4][2];
  logic [6:0] ga [2];
  logic [8:0] full_addr;
  logic [1:0] bank_sel;
  logic core_rvalid, irq;
  bdm_core_req_type core_req;
  bdm_pevt_type pevt;
  int seed, error_cnt, num_checks;

  bdm_top bdm_top_inst (.i_core_clk(core_clk), .i_resetn(resetn),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_core_req(core_req), .o_core_rdata(core_rdata),
    .o_core_rvalid(core_rvalid), .i_pevt(pevt), .o_bank_sel(bank_sel),
    .o_full_addr(full_addr), .o_pflags(pflags), .o_irq(irq));

  bdm_far_model bdm_far_model_inst (.i_core_clk(core_clk),
    .i_rvalid(core_rvalid), .i_rdata(core_rdata), .o_req(core_req),
    .o_pevt(pevt));

  // 25 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // full address of a direct access: bank over offset
  function automatic logic [8:0] dir_addr(input int b, input logic [6:0] a);
    return {2'(b), a};
  endfunction

  // writable flags take the byte, read-only ones keep their level
  function automatic logic [7:0] pf_wr(input logic [7:0] lv, wd);
    return (wd & ~`BDM_PF_RO_MASK) | (lv & `BDM_PF_RO_MASK);
  endfunction

  task automatic chk(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    error_cnt += bdm_far_model_inst.misses;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one apb transfer: setup, then access until ready
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] r, output logic e);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd, rd, er);
  endtask

  task automatic ard(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd, er);
    chk(rd, e);
  endtask

  task automatic cw(input logic [6:0] a, input logic [7:0] wd);
    bdm_far_model_inst.core(1'b1, 1'b0, a, wd, cb);
  endtask

  task automatic cr(input logic [6:0] a, input logic [7:0] e);
    bdm_far_model_inst.core(1'b0, 1'b0, a, 8'h00, cb);
    chk(cb, e);
  endtask

  // one-cycle event pulse, then let the flag and irq settle
  task automatic pulse(input int b);
    bdm_far_model_inst.set_evt(b, 1'b1);
    bdm_far_model_inst.set_evt(b, 1'b0);
    repeat (2) @(posedge core_clk);
  endtask

  // watchdog against a hang
  initial begin
    #2000000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    seed = 32'he4d786f0;
    error_cnt = 0;
    num_checks = 0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    ard(`BDM_APB_BANK, 32'h0);
    ard(`BDM_APB_PFLAG, 32'h0);
    ard(`BDM_APB_IRQ_STAT, 32'h0);
    $display("test reset ends");
    ga[0] = `BDM_BANK_TOP;
    ga[1] = 7'h20 + 7'(($random(seed) & 32'hFF) % 95);
    for (int b = 0; b < 4; b++) begin
      cw(`BDM_SFR_STATUS, 8'(b << 5));
      @(posedge core_clk);
      chk(bank_sel, b);
      for (int j = 0; j < 2; j++) begin
        gd[b][j] = 8'($random(seed));
        cw(ga[j], gd[b][j]);
      end
    end
    for (int b = 0; b < 4; b++) begin
      cw(`BDM_SFR_STATUS, 8'(b << 5));
      cr(`BDM_SFR_STATUS, 8'(b << 5));
      for (int j = 0; j < 2; j++) begin
        cr(ga[j], gd[b][j]);
        chk(full_addr, dir_addr(b, ga[j]));
      end
    end
    d = 32'($random(seed) & 32'hFF);
    bdm_far_model_inst.core_wr_rd(ga[1], d[7:0], cb);
    chk(cb, d[7:0]);
    $display("test banks ends");
    cw(`BDM_SFR_STATUS, 8'h00);
    cw(`BDM_SFR_PTR, 8'hFF);
    bdm_far_model_inst.core(1'b0, 1'b1, 7'h00, 8'h00, cb);
    chk(cb, gd[1][0]);
    chk(full_addr, 9'h0FF);
    cw(`BDM_SFR_STATUS, 8'h60);
    cr(`BDM_SFR_PTR, 8'hFF);
    cw(`BDM_SFR_PTR, 8'h7F);
    bdm_far_model_inst.core(1'b1, 1'b1, 7'h00, 8'h5A, cb);
    cw(`BDM_SFR_STATUS, 8'h40);
    cr(`BDM_BANK_TOP, 8'h5A);
    $display("test pointer ends");
    wr(`BDM_APB_IRQ_STAT, 32'h7);
    wr(`BDM_APB_PFLAG, 32'h0);
    wr(`BDM_APB_IRQ_MASK, 32'h2);
    pulse(7);
    chk(pflags, 8'h80);
    chk(irq, 1'b0);
    pulse(6);
    chk(pflags, 8'hC0);
    chk(irq, 1'b1);
    ard(`BDM_APB_IRQ_STAT, 32'h3);
    wr(`BDM_APB_IRQ_STAT, 32'h2);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0);
    chk(pflags, 8'hC0);
    bdm_far_model_inst.set_evt(5, 1'b1);
    bdm_far_model_inst.set_evt(4, 1'b1);
    repeat (3) @(posedge core_clk);
    chk(pflags, 8'hF0);
    ard(`BDM_APB_IRQ_STAT, 32'h5);
    d = 32'($random(seed) & 32'hFF);
    wr(`BDM_APB_PFLAG, d);
    ard(`BDM_APB_PFLAG, pf_wr(8'h30, d[7:0]));
    wr(`BDM_APB_PFLAG, 32'hFF);
    ard(`BDM_APB_PFLAG, pf_wr(8'h30, 8'hFF));
    bdm_far_model_inst.set_evt(5, 1'b0);
    bdm_far_model_inst.set_evt(4, 1'b0);
    repeat (3) @(posedge core_clk);
    chk(pflags, pf_wr(8'h00, 8'hFF));
    $display("test flags ends");
    ard(12'h018, 32'h0);
    chk(er, 1'b1);
    $display("test unmapped ends");
    give_verdict();
  end
endmodule // banked_data_memory_select_bench
